// >>> src/tes_sequencer.sv
// three-rail enable sequencer: open-drain rail holds released and re-asserted in order
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - after reset all three rails are held low until enable has stayed high through the first power-up timer.
// - enable high starts the power-up sequence by starting the first timer.
// - enable low during the first power-up timer resets it and returns to idle.
// - interrupted power-up handling applies only between timer 1 expiry and last release.
// - enable fall mid power-up restarts the running timer and finishes all releases.
// - after an interrupted power-up, wait about 120 ms before power-down begins.
// - interrupted power-down handling applies only after the first power-down timer expired.
// - enable rise mid power-down restarts the running timer and finishes all pull-downs.
// - after an interrupted power-down, wait about 120 ms before a new power-up.
// - enable low starts a timer, then rails pull low one by one, each after its delay.
// - first power-up and first power-down timers get an extra delay of about 400 us.
// - every timer counts the one master clock so their ratios stay fixed.
// - default order releases first, second, third and pulls low third, second, first.
// - each release starts the timer that delays the next release, until all three.
// - the three power-down delays are set apart from the three power-up delays.
module tes_sequencer
#(
    parameter logic [tes_pkg::CNT_W-1:0] P_TD1_CYC    = tes_pkg::TD_DEFAULT_CYC,
    parameter logic [tes_pkg::CNT_W-1:0] P_TD2_CYC    = tes_pkg::TD_DEFAULT_CYC,
    parameter logic [tes_pkg::CNT_W-1:0] P_TD3_CYC    = tes_pkg::TD_DEFAULT_CYC,
    parameter logic [tes_pkg::CNT_W-1:0] P_TD4_CYC    = tes_pkg::TD_DEFAULT_CYC,
    parameter logic [tes_pkg::CNT_W-1:0] P_TD5_CYC    = tes_pkg::TD_DEFAULT_CYC,
    parameter logic [tes_pkg::CNT_W-1:0] P_TD6_CYC    = tes_pkg::TD_DEFAULT_CYC,
    parameter logic [tes_pkg::CNT_W-1:0] P_EXTRA_CYC  = tes_pkg::EXTRA_CYC,
    parameter logic [tes_pkg::CNT_W-1:0] P_SETTLE_CYC = tes_pkg::SETTLE_CYC,
    parameter int unsigned               P_PD_SEQ     = tes_pkg::PD_SEQ_DEFAULT
)
(
    // clock, reset, clock enable
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_ce,
    // sequencing enable pin, asynchronous
    input  wire logic       i_en,
    // open-drain rail pins: enable high pulls the pin low
    output tes_pkg::tes_rail_s o_rail_out,
    output tes_pkg::tes_rail_s o_rail_oe,
    // status
    output logic [3:0]      o_phase,
    output logic            o_reverse_pending
);

    // ------------------------------------------------------------
    // power-down order lookup
    // ------------------------------------------------------------
    function automatic logic [5:0] pd_order(input int unsigned seq);
        logic [5:0] ord;
        ord = tes_pkg::PD_ORDER_SEQ1;
        case (seq)
            2: ord = tes_pkg::PD_ORDER_SEQ2;
            3: ord = tes_pkg::PD_ORDER_SEQ3;
            4: ord = tes_pkg::PD_ORDER_SEQ4;
            5: ord = tes_pkg::PD_ORDER_SEQ5;
            6: ord = tes_pkg::PD_ORDER_SEQ6;
            default: ord = tes_pkg::PD_ORDER_SEQ1;
        endcase
        return ord;
    endfunction

    // rail index pulled low at power-down step 0..2
    function automatic logic [1:0] pd_rail(input logic [1:0] step);
        logic [5:0] ord;
        logic [1:0] idx;
        ord = pd_order(P_PD_SEQ);
        idx = ord[5:4];
        case (step)
            2'd1:    idx = ord[3:2];
            2'd2:    idx = ord[1:0];
            default: idx = ord[5:4];
        endcase
        return idx;
    endfunction

    // ------------------------------------------------------------
    // timer loads
    // ------------------------------------------------------------
    localparam logic [tes_pkg::CNT_W-1:0] LD_UP1 = tes_pkg::CNT_W'(P_TD1_CYC + P_EXTRA_CYC);
    localparam logic [tes_pkg::CNT_W-1:0] LD_DN1 = tes_pkg::CNT_W'(P_TD4_CYC + P_EXTRA_CYC);

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    tes_pkg::tes_state_e       state_r;
    tes_pkg::tes_state_e       state_nxt;
    logic [2:0]                hold_r;
    logic [2:0]                hold_nxt;
    logic                      reverse_r;
    logic                      reverse_nxt;
    logic                      tmr_start_r;
    logic                      tmr_start_nxt;
    logic                      tmr_clear_r;
    logic                      tmr_clear_nxt;
    logic [tes_pkg::CNT_W-1:0] tmr_load_r;
    logic [tes_pkg::CNT_W-1:0] tmr_load_nxt;
    logic                      tmr_done;
    logic                      en_s;
    logic                      en_d_r;
    logic                      en_rise;
    logic                      en_fall;
    logic [2:0]                rail_out_r;

    // ------------------------------------------------------------
    // enable pin synchroniser and edges
    // ------------------------------------------------------------
    tes_sync2 u_en_sync
    (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_async   (i_en),
        .o_sync    (en_s)
    );

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            en_d_r <= 1'b0;
        end
        else if (i_ce)
        begin
            en_d_r <= en_s;
        end
    end

    assign en_rise = en_s & ~en_d_r;
    assign en_fall = ~en_s & en_d_r;

    // ------------------------------------------------------------
    // shared timer
    // ------------------------------------------------------------
    // a single counter serves all six delays and both pauses
    tes_timer u_timer
    (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_start   (tmr_start_r),
        .i_clear   (tmr_clear_r),
        .i_load    (tmr_load_r),
        .o_done    (tmr_done)
    );

    // ------------------------------------------------------------
    // sequencing state machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt     = state_r;
        hold_nxt      = hold_r;
        reverse_nxt   = reverse_r;
        tmr_start_nxt = 1'b0;
        tmr_clear_nxt = 1'b0;
        tmr_load_nxt  = tmr_load_r;
        case (state_r)
            tes_pkg::TES_IDLE:
            begin
                hold_nxt    = tes_pkg::RAIL_HOLD_RST;
                reverse_nxt = 1'b0;
                if (en_s)
                begin
                    state_nxt     = tes_pkg::TES_UP1;
                    tmr_start_nxt = 1'b1;
                    tmr_load_nxt  = LD_UP1;
                end
            end
            tes_pkg::TES_UP1:
            begin
                if (!en_s)
                begin
                    // glitch filter: nothing released yet, so just drop back
                    state_nxt     = tes_pkg::TES_IDLE;
                    tmr_clear_nxt = 1'b1;
                end
                else if (tmr_done)
                begin
                    hold_nxt[0]   = 1'b0;
                    state_nxt     = tes_pkg::TES_UP2;
                    tmr_start_nxt = 1'b1;
                    tmr_load_nxt  = P_TD2_CYC;
                end
            end
            tes_pkg::TES_UP2:
            begin
                reverse_nxt = reverse_r | en_fall;
                if (tmr_done)
                begin
                    hold_nxt[1]   = 1'b0;
                    state_nxt     = tes_pkg::TES_UP3;
                    tmr_start_nxt = 1'b1;
                    tmr_load_nxt  = P_TD3_CYC;
                end
                else if (en_fall)
                begin
                    tmr_start_nxt = 1'b1;
                    tmr_load_nxt  = P_TD2_CYC;
                end
            end
            tes_pkg::TES_UP3:
            begin
                reverse_nxt = reverse_r | en_fall;
                if (tmr_done)
                begin
                    hold_nxt[2] = 1'b0;
                    if (reverse_r | en_fall)
                    begin
                        state_nxt     = tes_pkg::TES_UP_SETTLE;
                        tmr_start_nxt = 1'b1;
                        tmr_load_nxt  = P_SETTLE_CYC;
                    end
                    else
                    begin
                        state_nxt = tes_pkg::TES_ON;
                    end
                end
                else if (en_fall)
                begin
                    tmr_start_nxt = 1'b1;
                    tmr_load_nxt  = P_TD3_CYC;
                end
            end
            tes_pkg::TES_UP_SETTLE:
            begin
                // enable may have come back during the pause; follow its level then
                if (tmr_done)
                begin
                    reverse_nxt = 1'b0;
                    if (en_s)
                    begin
                        state_nxt = tes_pkg::TES_ON;
                    end
                    else
                    begin
                        state_nxt     = tes_pkg::TES_DN1;
                        tmr_start_nxt = 1'b1;
                        tmr_load_nxt  = LD_DN1;
                    end
                end
            end
            tes_pkg::TES_ON:
            begin
                if (!en_s)
                begin
                    state_nxt     = tes_pkg::TES_DN1;
                    tmr_start_nxt = 1'b1;
                    tmr_load_nxt  = LD_DN1;
                end
            end
            tes_pkg::TES_DN1:
            begin
                if (en_s)
                begin
                    // no rail pulled low yet, so an early return needs no pause
                    state_nxt     = tes_pkg::TES_ON;
                    tmr_clear_nxt = 1'b1;
                end
                else if (tmr_done)
                begin
                    hold_nxt[pd_rail(2'd0)] = 1'b1;
                    state_nxt               = tes_pkg::TES_DN2;
                    tmr_start_nxt           = 1'b1;
                    tmr_load_nxt            = P_TD5_CYC;
                end
            end
            tes_pkg::TES_DN2:
            begin
                reverse_nxt = reverse_r | en_rise;
                if (tmr_done)
                begin
                    hold_nxt[pd_rail(2'd1)] = 1'b1;
                    state_nxt               = tes_pkg::TES_DN3;
                    tmr_start_nxt           = 1'b1;
                    tmr_load_nxt            = P_TD6_CYC;
                end
                else if (en_rise)
                begin
                    tmr_start_nxt = 1'b1;
                    tmr_load_nxt  = P_TD5_CYC;
                end
            end
            tes_pkg::TES_DN3:
            begin
                reverse_nxt = reverse_r | en_rise;
                if (tmr_done)
                begin
                    hold_nxt[pd_rail(2'd2)] = 1'b1;
                    if (reverse_r | en_rise)
                    begin
                        state_nxt     = tes_pkg::TES_DN_SETTLE;
                        tmr_start_nxt = 1'b1;
                        tmr_load_nxt  = P_SETTLE_CYC;
                    end
                    else
                    begin
                        state_nxt = tes_pkg::TES_IDLE;
                    end
                end
                else if (en_rise)
                begin
                    tmr_start_nxt = 1'b1;
                    tmr_load_nxt  = P_TD6_CYC;
                end
            end
            tes_pkg::TES_DN_SETTLE:
            begin
                if (tmr_done)
                begin
                    reverse_nxt = 1'b0;
                    state_nxt   = tes_pkg::TES_IDLE;
                end
            end
            default:
            begin
                state_nxt     = tes_pkg::TES_IDLE;
                hold_nxt      = tes_pkg::RAIL_HOLD_RST;
                tmr_clear_nxt = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state and timer request registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            state_r     <= tes_pkg::TES_IDLE;
            reverse_r   <= 1'b0;
            tmr_start_r <= 1'b0;
            tmr_clear_r <= 1'b0;
            tmr_load_r  <= '0;
        end
        else if (i_ce)
        begin
            state_r     <= state_nxt;
            reverse_r   <= reverse_nxt;
            tmr_start_r <= tmr_start_nxt;
            tmr_clear_r <= tmr_clear_nxt;
            tmr_load_r  <= tmr_load_nxt;
        end
    end

    // ------------------------------------------------------------
    // rail pin drive
    // ------------------------------------------------------------
    // the pins never drive high; the pull-up sets the released level
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            hold_r     <= tes_pkg::RAIL_HOLD_RST;
            rail_out_r <= 3'h0;
        end
        else if (i_ce)
        begin
            hold_r     <= hold_nxt;
            rail_out_r <= 3'h0;
        end
    end

    assign o_rail_oe         = tes_pkg::tes_rail_s'(hold_r);
    assign o_rail_out        = tes_pkg::tes_rail_s'(rail_out_r);
    assign o_phase           = state_r;
    assign o_reverse_pending = reverse_r;

endmodule

`default_nettype wire

// >>> src/tes_pkg.sv
// package: constants, types and timing for the three-rail enable sequencer
package tes_pkg;

    // ------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------
    localparam longint unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned     CNT_W        = 32;

    // default rail delay, extra delay on timers 1 and 4, settle pause
    localparam longint unsigned TD_DEFAULT_MS = 10;
    localparam longint unsigned EXTRA_US      = 400;
    localparam longint unsigned SETTLE_MS     = 120;

    localparam logic [CNT_W-1:0] TD_DEFAULT_CYC =
        CNT_W'((TD_DEFAULT_MS * CLK_HZ + 64'd999) / 64'd1000);
    localparam logic [CNT_W-1:0] EXTRA_CYC =
        CNT_W'((EXTRA_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
    localparam logic [CNT_W-1:0] SETTLE_CYC =
        CNT_W'((SETTLE_MS * CLK_HZ + 64'd999) / 64'd1000);

    // ------------------------------------------------------------
    // power-down orders, one 2-bit rail index per step, step 0 on top
    // rail index 0 = first, 1 = second, 2 = third
    // ------------------------------------------------------------
    localparam int unsigned PD_SEQ_DEFAULT = 1;
    localparam logic [5:0]  PD_ORDER_SEQ1  = 6'h24;
    localparam logic [5:0]  PD_ORDER_SEQ2  = 6'h21;
    localparam logic [5:0]  PD_ORDER_SEQ3  = 6'h18;
    localparam logic [5:0]  PD_ORDER_SEQ4  = 6'h12;
    localparam logic [5:0]  PD_ORDER_SEQ5  = 6'h09;
    localparam logic [5:0]  PD_ORDER_SEQ6  = 6'h06;

    // rails held low after reset
    localparam logic [2:0]  RAIL_HOLD_RST  = 3'h7;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TES_IDLE      = 4'b0000,
        TES_UP1       = 4'b0001,
        TES_UP2       = 4'b0010,
        TES_UP3       = 4'b0011,
        TES_UP_SETTLE = 4'b0100,
        TES_ON        = 4'b0101,
        TES_DN1       = 4'b0110,
        TES_DN2       = 4'b0111,
        TES_DN3       = 4'b1000,
        TES_DN_SETTLE = 4'b1001
    } tes_state_e;

    // one bit per open-drain rail pin, packed so bit 0 is the first rail
    typedef struct packed {
        logic rail_go_third;
        logic rail_go_second;
        logic rail_go_first;
    } tes_rail_s;

endpackage

// >>> src/tes_sync2.sv
// two-flop synchroniser for the asynchronous enable pin
`timescale 1ns/1ps
`default_nettype none

module tes_sync2
(
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    // async level in, synchronised level out
    input  wire logic i_async,
    output logic      o_sync
);

    logic meta_r;
    logic sync_r;

    // meta_r feeds only sync_r
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else if (i_ce)
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

`default_nettype wire

// >>> src/tes_timer.sv
// one-shot down counter; all sequencing delays run on this one time base
`timescale 1ns/1ps
`default_nettype none

module tes_timer
(
    // clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rstn,
    input  wire logic                      i_ce,
    // control
    input  wire logic                      i_start,
    input  wire logic                      i_clear,
    input  wire logic [tes_pkg::CNT_W-1:0] i_load,
    // status
    output logic                           o_done
);

    logic [tes_pkg::CNT_W-1:0] cnt_r;
    logic                      run_r;
    logic                      done_r;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            cnt_r  <= '0;
            run_r  <= 1'b0;
            done_r <= 1'b0;
        end
        else if (i_ce)
        begin
            done_r <= 1'b0;
            if (i_clear)
            begin
                run_r <= 1'b0;
            end
            else if (i_start)
            begin
                // a zero load would wrap and run through the whole counter range, so count it as one
                cnt_r <= (i_load == '0) ? tes_pkg::CNT_W'(1) : i_load;
                run_r <= 1'b1;
            end
            else if (run_r)
            begin
                if (cnt_r == tes_pkg::CNT_W'(1))
                begin
                    run_r  <= 1'b0;
                    done_r <= 1'b1;
                end
                else
                begin
                    cnt_r <= cnt_r - tes_pkg::CNT_W'(1);
                end
            end
        end
    end

    assign o_done = done_r;

endmodule

`default_nettype wire

// >>> testbench/tes_sequencer_assertions.sv
// checker: order and timing properties of the rail sequencer ports
`timescale 1ns/1ps
`default_nettype none

module tes_sequencer_assertions
#(
    parameter logic [31:0] P_TD1_CYC    = 32'h14,
    parameter logic [31:0] P_TD2_CYC    = 32'h14,
    parameter logic [31:0] P_TD4_CYC    = 32'h14,
    parameter logic [31:0] P_TD5_CYC    = 32'h14,
    parameter logic [31:0] P_EXTRA_CYC  = 32'h05,
    parameter logic [31:0] P_SETTLE_CYC = 32'h32
)
(
    // clock and reset
    input wire logic               i_clk_sys,
    input wire logic               i_rstn,
    input wire logic               i_ce,
    // watched pins
    input wire logic               i_en,
    input wire tes_pkg::tes_rail_s o_rail_out,
    input wire tes_pkg::tes_rail_s o_rail_oe,
    input wire logic [3:0]         o_phase,
    input wire logic               o_reverse_pending
);
    // ------------------------------------------------------------
    // helper: cycles spent in the current phase
    // ------------------------------------------------------------
    localparam int D2 = int'(P_TD2_CYC) + 2;
    localparam int D5 = int'(P_TD5_CYC) + 2;
    logic [3:0]  ph_r;
    logic [31:0] cnt_r;

    always_ff @(posedge i_clk_sys)
    begin
        ph_r  <= o_phase;
        cnt_r <= (!i_rstn || o_phase != ph_r) ? 32'h0 : cnt_r + 32'h1;
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_RST_HOLD: assert property (disable iff (1'b0) !i_rstn |=> o_rail_oe == 3'h7 && o_rail_out == 3'h0)
        else $error("rails not held low after reset");
    AST_GLITCH: assert property (o_phase == 4'h1 ##1 o_phase == 4'h0 |-> o_rail_oe == 3'h7 && !o_reverse_pending)
        else $error("enable glitch not filtered");
    AST_UP_GAP: assert property ($fell(o_rail_oe.rail_go_first) |-> ##D2
        ($fell(o_rail_oe.rail_go_second) || o_reverse_pending)) else $error("second release off time");
    AST_DN_GAP: assert property ($rose(o_rail_oe.rail_go_third) |-> ##D5
        ($rose(o_rail_oe.rail_go_second) || o_reverse_pending)) else $error("second pull-down off time");
    AST_ORDER: assert property ($rose(o_rail_oe.rail_go_first) |-> o_rail_oe.rail_go_second && o_rail_oe.rail_go_third)
        else $error("first rail pulled low too early");
    AST_EXTRA_UP: assert property (o_phase == 4'h1 ##1 o_phase == 4'h2 |-> cnt_r >= P_TD1_CYC + P_EXTRA_CYC)
        else $error("first power-up delay too short");
    AST_EXTRA_DN: assert property (o_phase == 4'h6 ##1 o_phase == 4'h7 |-> cnt_r >= P_TD4_CYC + P_EXTRA_CYC)
        else $error("first power-down delay too short");
    AST_UP_DONE: assert property ($rose(o_phase == 4'h4) |-> o_rail_oe == 3'h0 && o_reverse_pending)
        else $error("interrupted power-up left rails held");
    AST_DN_DONE: assert property ($rose(o_phase == 4'h9) |-> o_rail_oe == 3'h7 && o_reverse_pending)
        else $error("interrupted power-down left rails released");
    AST_SETTLE_UP: assert property (o_phase == 4'h4 ##1 o_phase != 4'h4 |-> cnt_r >= P_SETTLE_CYC)
        else $error("pause after power-up too short");
    AST_SETTLE_DN: assert property (o_phase == 4'h9 ##1 o_phase != 4'h9 |-> cnt_r >= P_SETTLE_CYC)
        else $error("pause after power-down too short");

    COV_UP_SETTLE: cover property (o_phase == 4'h4);
    COV_DN_SETTLE: cover property (o_phase == 4'h9);
    COV_GLITCH: cover property (o_phase == 4'h1 ##1 o_phase == 4'h0);
endmodule

`default_nettype wire

// >>> testbench/tes_partner.sv
// partner: enable source and the pulled-up rail pins of the regulators
`timescale 1ns/1ps
`default_nettype none

module tes_partner
(
    // enable source
    input  wire logic               i_vcc_ok,
    input  wire logic               i_req,
    output logic                    o_en,
    // rail pins
    input  wire tes_pkg::tes_rail_s i_oe,
    input  wire tes_pkg::tes_rail_s i_out,
    output tes_pkg::tes_rail_s      o_pin
);
    // dedicated logic output, kept low until the sequencer supply is valid
    assign o_en = i_vcc_ok & i_req;
    // a released pin floats up to the pull-up level
    assign o_pin = (i_oe & i_out) | ~i_oe;
endmodule

`default_nettype wire

// >>> testbench/tes_sequencer_bench.sv
// testbench: normal, glitch and interrupted sequences of the rail sequencer
`timescale 1ns/1ps
`default_nettype none

module tes_sequencer_bench;
    typedef struct packed { logic en; logic [3:0] ph; logic [2:0] pin; } tes_row_s;
    // normal power-up then power-down; pin bit 0 is the first rail
    localparam tes_row_s ROWS [6] = '{'{1'b1, 4'h2, 3'h1}, '{1'b1, 4'h3, 3'h3}, '{1'b1, 4'h5, 3'h7},
                                      '{1'b0, 4'h7, 3'h3}, '{1'b0, 4'h8, 3'h1}, '{1'b0, 4'h0, 3'h0}};
    localparam int SETTLE = 50;

    logic               i_clk_sys   = 1'b0;
    logic               i_rstn      = 1'b0;
    logic               i_ce        = 1'b1;
    logic               vcc_ok      = 1'b0;
    logic               en_req      = 1'b0;
    logic               en;
    tes_pkg::tes_rail_s oe;
    tes_pkg::tes_rail_s out;
    tes_pkg::tes_rail_s pin;
    logic [3:0]         phase;
    logic               rev;
    int                 miscompares = 0;
    int                 n_compared  = 0;
    int                 cycles      = 0;
    int                 waited      = 0;

    always #2.5 i_clk_sys = ~i_clk_sys;

    tes_sequencer #(.P_TD1_CYC(32'h14), .P_TD2_CYC(32'h18), .P_TD3_CYC(32'h1C), .P_TD4_CYC(32'h16),
                    .P_TD5_CYC(32'h1A), .P_TD6_CYC(32'h1E), .P_EXTRA_CYC(32'h05), .P_SETTLE_CYC(32'h32))
    i_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce), .i_en(en), .o_rail_out(out),
           .o_rail_oe(oe), .o_phase(phase), .o_reverse_pending(rev));

    tes_partner i_partner (.i_vcc_ok(vcc_ok), .i_req(en_req), .o_en(en), .i_oe(oe), .i_out(out), .o_pin(pin));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    // bounded wait for a phase; waited keeps the cycle count for pause checks
    task automatic wait_ph(input logic [3:0] p);
        waited = 0;
        while (phase !== p && waited < 400)
        begin
            step(1);
            waited++;
        end
        chk("phase", p, phase);
    endtask

    // a hang ends the run as a mismatch
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        step(3);
        chk("pin", 4'h0, {1'b0, pin});
        chk("out", 4'h0, {1'b0, out});
        i_rstn = 1'b1;
        vcc_ok = 1'b1;
        step(10);
        chk("phase", 4'h0, phase);
        chk("pin", 4'h0, {1'b0, pin});
        $display("test reset done");
        foreach (ROWS[k])
        begin
            en_req = ROWS[k].en;
            wait_ph(ROWS[k].ph);
            chk("pin", {1'b0, ROWS[k].pin}, {1'b0, pin});
            chk("rev", 4'h0, {3'h0, rev});
        end
        $display("test rows done");
        en_req = 1'b1;
        wait_ph(4'h1);
        step(10);
        en_req = 1'b0;
        wait_ph(4'h0);
        chk("pin", 4'h0, {1'b0, pin});
        chk("rev", 4'h0, {3'h0, rev});
        $display("test glitch done");
        en_req = 1'b1;
        wait_ph(4'h2);
        step(4);
        en_req = 1'b0;
        wait_ph(4'h4);
        chk("pin", 4'h7, {1'b0, pin});
        chk("rev", 4'h1, {3'h0, rev});
        wait_ph(4'h6);
        chk("pause", 4'h1, {3'h0, waited >= SETTLE});
        wait_ph(4'h0);
        chk("pin", 4'h0, {1'b0, pin});
        $display("test broken power-up done");
        en_req = 1'b1;
        wait_ph(4'h5);
        en_req = 1'b0;
        wait_ph(4'h7);
        step(4);
        en_req = 1'b1;
        wait_ph(4'h9);
        chk("pin", 4'h0, {1'b0, pin});
        chk("rev", 4'h1, {3'h0, rev});
        wait_ph(4'h1);
        chk("pause", 4'h1, {3'h0, waited >= SETTLE});
        wait_ph(4'h5);
        $display("test broken power-down done");
        en_req = 1'b0;
        wait_ph(4'h6);
        step(4);
        en_req = 1'b1;
        wait_ph(4'h5);
        chk("pin", 4'h7, {1'b0, pin});
        chk("rev", 4'h0, {3'h0, rev});
        $display("test early rise done");
        i_ce   = 1'b0;
        en_req = 1'b0;
        step(40);
        chk("phase", 4'h5, phase);
        chk("pin", 4'h7, {1'b0, pin});
        i_ce = 1'b1;
        wait_ph(4'h6);
        step(4);
        i_rstn = 1'b0;
        step(2);
        chk("pin", 4'h0, {1'b0, pin});
        i_rstn = 1'b1;
        step(2);
        chk("phase", 4'h0, phase);
        $display("test freeze and reset done");
        end_of_test();
    end
endmodule

bind tes_sequencer tes_sequencer_assertions #(.P_TD1_CYC(P_TD1_CYC), .P_TD2_CYC(P_TD2_CYC),
    .P_TD4_CYC(P_TD4_CYC), .P_TD5_CYC(P_TD5_CYC), .P_EXTRA_CYC(P_EXTRA_CYC), .P_SETTLE_CYC(P_SETTLE_CYC))
i_chk (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce), .i_en(i_en), .o_rail_out(o_rail_out),
       .o_rail_oe(o_rail_oe), .o_phase(o_phase), .o_reverse_pending(o_reverse_pending));

`default_nettype wire
